// >>> include/uspl_pkg.sv
// shared constants and types of the upgrade serial port link
`default_nettype none
package uspl_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned IDLE_UNIT_MS  = 1000;
  localparam int unsigned TURN_STEP_MS  = 10;
  localparam int unsigned IDLE_UNIT_CYC = IDLE_UNIT_MS * (1_000_000 / CLK_PERIOD_NS);
  localparam int unsigned TURN_STEP_CYC = TURN_STEP_MS * (1_000_000 / CLK_PERIOD_NS);
  // selectable bit rates, index is the baud select code
  localparam int unsigned BAUD_SEL_MAX = 6;
  localparam int unsigned BAUD_RATE [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
  // register offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_IDLE    = 8'h04;
  localparam logic [7:0] OFF_TURN    = 8'h08;
  localparam logic [7:0] OFF_STATION = 8'h0C;
  localparam logic [7:0] OFF_TXDATA  = 8'h10;
  localparam logic [7:0] OFF_RXDATA  = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_EV_STAT = 8'h1C;
  localparam logic [7:0] OFF_EV_CLR  = 8'h20;
  localparam logic [7:0] OFF_EV_EN   = 8'h24;
  // event bit positions
  localparam int unsigned EV_RX_DONE = 0;
  localparam int unsigned EV_TX_DONE = 1;
  localparam int unsigned EV_PAR_ERR = 2;
  localparam int unsigned EV_FRM_ERR = 3;
  localparam int unsigned EV_LOST    = 4;
  localparam int unsigned EV_ID_REJ  = 5;
  localparam int unsigned EV_W       = 6;
  // status bit positions
  localparam int unsigned ST_TX_BUSY = 0;
  localparam int unsigned ST_RX_FULL = 1;
  localparam int unsigned ST_SESSION = 2;
  // station identifier layout: seven hex characters, first in the top nibble
  localparam int unsigned STATION_W     = 28;
  localparam logic [3:0]  STATION_FIRST_MIN = 4'hA;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ODD  = 2'h1,
    PAR_EVEN = 2'h2
  } uspl_parity_e;
  // control register, bits 6..0
  typedef struct packed {
    logic         multidrop;
    uspl_parity_e parity;
    logic         stop2;
    logic [2:0]   baud;
  } uspl_cfg_s;
  // reset values
  localparam uspl_cfg_s   CFG_DEF     = '{multidrop: 1'b0, parity: PAR_ODD, stop2: 1'b0,
                                          baud: 3'h6};
  localparam logic [7:0]  IDLE_DEF    = 8'h0A;
  localparam logic [7:0]  TURN_DEF    = 8'h00;
  localparam logic [27:0] STATION_DEF = 28'hA000001;
endpackage : uspl_pkg
`default_nettype wire

// >>> rtl/uspl_bit_timer.sv
// bit period timer with selectable rate and half-period restart
`timescale 1ns/100ps
`default_nettype none
module uspl_bit_timer #(
  parameter int unsigned CLK_HZ = uspl_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // control
  input  wire logic [2:0] baud_sel,
  input  wire logic       restart,
  input  wire logic       half,
  // timing
  output logic            tick
);
  localparam int unsigned CNT_W = $clog2(CLK_HZ / uspl_pkg::BAUD_RATE[0] + 1);

  if (CLK_HZ / uspl_pkg::BAUD_RATE[uspl_pkg::BAUD_SEL_MAX] < 4)
  begin : g_chk
    $error("clock too slow for the fastest bit rate");
  end

  // unused code 7 falls back to the fastest rate
  function automatic logic [CNT_W-1:0] bit_cycles(input logic [2:0] sel);
    int unsigned idx;
    idx = (32'(sel) > uspl_pkg::BAUD_SEL_MAX) ? uspl_pkg::BAUD_SEL_MAX : 32'(sel);
    bit_cycles = CNT_W'(CLK_HZ / uspl_pkg::BAUD_RATE[idx]);
  endfunction : bit_cycles

  logic [CNT_W-1:0] cnt_reg;
  wire  [CNT_W-1:0] full_load = bit_cycles(baud_sel) - 1'b1;
  wire  [CNT_W-1:0] half_load = bit_cycles(baud_sel) >> 1;

  assign tick = (cnt_reg == '0) && !restart;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= '0;
    else if (restart)
      cnt_reg <= half ? half_load : full_load;
    else if (cnt_reg == '0)
      cnt_reg <= full_load;
    else
      cnt_reg <= cnt_reg - 1'b1;
  end
endmodule : uspl_bit_timer
`default_nettype wire

// >>> rtl/uspl_top.sv
// configurable serial port for firmware upgrade traffic
//
// Overview of operation
// - bit rate 300 to 19200 selectable, 19200 after reset
// - one or two stop bits as configured, one after reset
// - odd, even or no parity; odd after reset; received parity checked
// - gap since last message timed in whole seconds against idle limit
// - idle limit reached: session dropped, wait for new connection
// - turnaround delay in 0.01 s steps before sending, zero after reset
// - station identifier: up to 7 hex chars, first one A to F
// - multi-drop: line driver released between frames; no addressing by station identifier
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module uspl_top #(
  parameter int unsigned CLK_HZ        = uspl_pkg::CLK_HZ,
  parameter int unsigned IDLE_UNIT_CYC = uspl_pkg::IDLE_UNIT_CYC,
  parameter int unsigned TURN_STEP_CYC = uspl_pkg::TURN_STEP_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // serial line
  input  wire logic        rxd,
  output logic             txd,
  output logic             txd_oe,
  output logic             rts,
  // loader side
  output logic             session_active,
  output logic             link_lost,
  output logic      [27:0] station_id,
  output logic             irq
);
  localparam int unsigned SEC_W  = $clog2(IDLE_UNIT_CYC);
  localparam int unsigned TURN_W = $clog2(TURN_STEP_CYC);

  if (IDLE_UNIT_CYC < 2 || TURN_STEP_CYC < 2)
  begin : g_chk
    $error("second and turnaround step need at least two cycles");
  end

  typedef enum logic [5:0] {
    T_IDLE  = 6'h01,
    T_TURN  = 6'h02,
    T_START = 6'h04,
    T_DATA  = 6'h08,
    T_PAR   = 6'h10,
    T_STOP  = 6'h20
  } uspl_tx_e;
  typedef enum logic [4:0] {
    R_IDLE  = 5'h01,
    R_START = 5'h02,
    R_DATA  = 5'h04,
    R_PAR   = 5'h08,
    R_STOP  = 5'h10
  } uspl_rx_e;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit
  function automatic logic par_bit(input logic [7:0] d, input uspl_pkg::uspl_parity_e p);
    par_bit = (p == uspl_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction : par_bit

  localparam int unsigned EV_W_C = uspl_pkg::EV_W;
  uspl_pkg::uspl_cfg_s cfg_reg;
  logic [7:0]          idle_lim_reg;
  logic [7:0]          turn_reg;
  logic [27:0]         station_reg;
  logic [EV_W_C-1:0]   ev_stat_reg;
  logic [EV_W_C-1:0]   ev_en_reg;
  uspl_tx_e            tx_st;
  uspl_tx_e            tx_next;
  uspl_rx_e            rx_st;
  uspl_rx_e            rx_next;
  logic [7:0]          tx_byte_reg;
  logic [2:0]          tx_bit_reg;
  logic [7:0]          turn_left_reg;
  logic [TURN_W-1:0]   turn_cyc_reg;
  logic [7:0]          rx_shift_reg;
  logic [2:0]          rx_bit_reg;
  logic                rx_perr_reg;
  logic [7:0]          rx_data_reg;
  logic                rx_full_reg;
  logic [SEC_W-1:0]    sec_cnt_reg;
  logic [7:0]          idle_secs_reg;
  logic                tx_tick;
  logic                rx_tick;

  // register decode
  wire wr_ctrl    = reg_wr && hit(reg_addr, uspl_pkg::OFF_CTRL);
  wire wr_idle    = reg_wr && hit(reg_addr, uspl_pkg::OFF_IDLE) && (reg_wdata[7:0] != 8'h00);
  wire wr_turn    = reg_wr && hit(reg_addr, uspl_pkg::OFF_TURN);
  wire wr_station = reg_wr && hit(reg_addr, uspl_pkg::OFF_STATION);
  wire wr_txd     = reg_wr && hit(reg_addr, uspl_pkg::OFF_TXDATA);
  wire wr_clr     = reg_wr && hit(reg_addr, uspl_pkg::OFF_EV_CLR);
  wire wr_en      = reg_wr && hit(reg_addr, uspl_pkg::OFF_EV_EN);
  wire rd_rxd     = reg_rd && hit(reg_addr, uspl_pkg::OFF_RXDATA);
  wire id_ok      = reg_wdata[27:24] >= uspl_pkg::STATION_FIRST_MIN;

  // timers: tx holds in restart until its start bit, rx aligns on mid-bit
  // rate select
  uspl_bit_timer #(.CLK_HZ(CLK_HZ)) u_tx_timer (
    .mclk     (mclk),
    .resetn   (resetn),
    .baud_sel (cfg_reg.baud),
    .restart  (tx_st == T_IDLE || tx_st == T_TURN),
    .half     (1'b0),
    .tick     (tx_tick)
  );
  uspl_bit_timer #(.CLK_HZ(CLK_HZ)) u_rx_timer (
    .mclk     (mclk),
    .resetn   (resetn),
    .baud_sel (cfg_reg.baud),
    .restart  (rx_st == R_IDLE),
    .half     (1'b1),
    .tick     (rx_tick)
  );

  // transmit path; a write while busy is dropped, software polls busy
  wire tx_go     = wr_txd && (tx_st == T_IDLE);
  wire turn_step = (turn_cyc_reg == TURN_W'(TURN_STEP_CYC - 1));
  // delay counted in 0.01 s steps
  wire turn_done = turn_step && (turn_left_reg == 8'h01);
  wire no_par    = (cfg_reg.parity != uspl_pkg::PAR_ODD) && (cfg_reg.parity != uspl_pkg::PAR_EVEN);
  wire tx_last   = (tx_st == T_STOP) && tx_tick && (tx_bit_reg == {2'b00, cfg_reg.stop2});
  wire tx_par    = par_bit(tx_byte_reg, cfg_reg.parity);
  wire tx_line   = (tx_st == T_START) ? 1'b0 :
                   (tx_st == T_DATA)  ? tx_byte_reg[tx_bit_reg] :
                   (tx_st == T_PAR)   ? tx_par : 1'b1;

  always_comb
  begin
    tx_next = tx_st;
    case (tx_st)
      T_IDLE:  if (tx_go) tx_next = (turn_reg == 8'h00) ? T_START : T_TURN;
      T_TURN:  if (turn_done) tx_next = T_START;
      T_START: if (tx_tick) tx_next = T_DATA;
      T_DATA:  if (tx_tick && tx_bit_reg == 3'h7) tx_next = no_par ? T_STOP : T_PAR;
      T_PAR:   if (tx_tick) tx_next = T_STOP;
      T_STOP:  if (tx_last) tx_next = T_IDLE;
      default: tx_next = T_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_st         <= T_IDLE;
      tx_byte_reg   <= 8'h00;
      tx_bit_reg    <= 3'h0;
      turn_left_reg <= 8'h00;
      turn_cyc_reg  <= '0;
    end
    else
    begin
      tx_st        <= tx_next;
      tx_bit_reg   <= (tx_st != T_DATA && tx_st != T_STOP) ? 3'h0 :
                      tx_tick ? tx_bit_reg + 3'h1 : tx_bit_reg;
      turn_cyc_reg <= (tx_st != T_TURN || turn_step) ? '0 : turn_cyc_reg + 1'b1;
      if (tx_go)
      begin
        tx_byte_reg   <= reg_wdata[7:0];
        turn_left_reg <= turn_reg;
      end
      else if (tx_st == T_TURN && turn_step)
        turn_left_reg <= turn_left_reg - 8'h01;
    end
  end

  // receive path
  wire rx_end   = (rx_st == R_STOP) && rx_tick;
  wire rx_good  = rx_end && rxd && !rx_perr_reg;
  wire frm_err  = rx_end && !rxd;
  wire par_bad  = (rx_st == R_PAR) && rx_tick && (rxd != par_bit(rx_shift_reg, cfg_reg.parity));

  always_comb
  begin
    rx_next = rx_st;
    case (rx_st)
      R_IDLE:  if (!rxd) rx_next = R_START;
      R_START: if (rx_tick) rx_next = rxd ? R_IDLE : R_DATA;
      R_DATA:  if (rx_tick && rx_bit_reg == 3'h7) rx_next = no_par ? R_STOP : R_PAR;
      R_PAR:   if (rx_tick) rx_next = R_STOP;
      R_STOP:  if (rx_tick) rx_next = R_IDLE;
      default: rx_next = R_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_st        <= R_IDLE;
      rx_shift_reg <= 8'h00;
      rx_bit_reg   <= 3'h0;
      rx_perr_reg  <= 1'b0;
    end
    else
    begin
      rx_st       <= rx_next;
      rx_bit_reg  <= (rx_st != R_DATA) ? 3'h0 : rx_tick ? rx_bit_reg + 3'h1 : rx_bit_reg;
      rx_perr_reg <= (rx_st == R_START) ? 1'b0 : (rx_perr_reg | par_bad);
      if (rx_st == R_DATA && rx_tick)
        rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
    end
  end

  // idle supervision
  wire sec_wrap = (sec_cnt_reg == SEC_W'(IDLE_UNIT_CYC - 1));
  wire lost     = session_active && !rx_good && (idle_secs_reg >= idle_lim_reg);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sec_cnt_reg    <= '0;
      idle_secs_reg  <= 8'h00;
      session_active <= 1'b0;
      link_lost      <= 1'b0;
    end
    else
    begin
      link_lost <= lost;
      if (rx_good || lost || !session_active)
      begin
        sec_cnt_reg   <= '0;
        idle_secs_reg <= 8'h00;
      end
      else
      begin
        sec_cnt_reg <= sec_wrap ? '0 : sec_cnt_reg + 1'b1;
        if (sec_wrap && idle_secs_reg != 8'hFF)
          idle_secs_reg <= idle_secs_reg + 8'h01;
      end
      if (rx_good)
        session_active <= 1'b1;
      else if (lost)
        session_active <= 1'b0;
    end
  end

  // events: a set in the clearing cycle wins
  wire [EV_W_C-1:0] ev_set = {wr_station && !id_ok, lost, frm_err, par_bad,
                              tx_last, rx_good};
  wire [EV_W_C-1:0] ev_next = (ev_stat_reg & ~(wr_clr ? reg_wdata[EV_W_C-1:0] : '0)) | ev_set;
  wire [31:0] status_word = {29'h0, session_active, rx_full_reg, tx_st != T_IDLE};
  wire [31:0] rd_mux =
    hit(reg_addr, uspl_pkg::OFF_CTRL)    ? {25'h0, cfg_reg} :
    hit(reg_addr, uspl_pkg::OFF_IDLE)    ? {24'h0, idle_lim_reg} :
    hit(reg_addr, uspl_pkg::OFF_TURN)    ? {24'h0, turn_reg} :
    hit(reg_addr, uspl_pkg::OFF_STATION) ? {4'h0, station_reg} :
    hit(reg_addr, uspl_pkg::OFF_RXDATA)  ? {24'h0, rx_data_reg} :
    hit(reg_addr, uspl_pkg::OFF_STATUS)  ? status_word :
    hit(reg_addr, uspl_pkg::OFF_EV_STAT) ? {26'h0, ev_stat_reg} :
    hit(reg_addr, uspl_pkg::OFF_EV_EN)   ? {26'h0, ev_en_reg} : 32'h0;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_reg      <= uspl_pkg::CFG_DEF;
      idle_lim_reg <= uspl_pkg::IDLE_DEF;
      turn_reg     <= uspl_pkg::TURN_DEF;
      station_reg  <= uspl_pkg::STATION_DEF;
      ev_stat_reg  <= '0;
      ev_en_reg    <= '0;
      rx_data_reg  <= 8'h00;
      rx_full_reg  <= 1'b0;
      reg_rdata    <= 32'h0;
      irq          <= 1'b0;
    end
    else
    begin
      if (wr_ctrl) cfg_reg <= uspl_pkg::uspl_cfg_s'(reg_wdata[6:0]);
      if (wr_idle) idle_lim_reg <= reg_wdata[7:0];
      if (wr_turn) turn_reg <= reg_wdata[7:0];
      // identifier with a digit first is refused
      if (wr_station && id_ok) station_reg <= reg_wdata[27:0];
      if (wr_en) ev_en_reg <= reg_wdata[EV_W_C-1:0];
      ev_stat_reg <= ev_next;
      irq         <= |(ev_next & ev_en_reg);
      reg_rdata   <= reg_rd ? rd_mux : 32'h0;
      if (rx_good) rx_data_reg <= rx_shift_reg;
      rx_full_reg <= rx_good | (rx_full_reg & ~rd_rxd & ~lost);
    end
  end

  // line drivers registered so the pins never glitch
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      txd    <= 1'b1;
      txd_oe <= 1'b1;
      rts    <= 1'b0;
    end
    else
    begin
      txd    <= tx_line;
      rts    <= (tx_st != T_IDLE);
      // multi-drop releases the line between frames
      txd_oe <= !cfg_reg.multidrop || (tx_st != T_IDLE && tx_st != T_TURN);
    end
  end

  assign station_id = station_reg;

  property p_start_low;
    @(posedge mclk) disable iff (!resetn) tx_st == T_START |=> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_stop_high;
    @(posedge mclk) disable iff (!resetn) tx_st == T_STOP |=> txd;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
  property p_stop_count;
    @(posedge mclk) disable iff (!resetn)
      tx_st == T_STOP && tx_tick && !tx_last |-> cfg_reg.stop2 && tx_bit_reg == 3'h0;
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("stop length wrong");
  property p_parity;
    @(posedge mclk) disable iff (!resetn)
      tx_st == T_PAR |=> txd == par_bit(tx_byte_reg, cfg_reg.parity);
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");
  property p_no_par;
    @(posedge mclk) disable iff (!resetn) no_par |-> tx_st != T_PAR && rx_st != R_PAR;
  endproperty
  a_no_par: assert property (p_no_par) else $error("parity slot without parity");
  property p_zero_turn;
    @(posedge mclk) disable iff (!resetn) tx_go && turn_reg == 8'h00 |=> tx_st == T_START;
  endproperty
  a_zero_turn: assert property (p_zero_turn) else $error("zero delay not immediate");
  property p_rts;
    @(posedge mclk) disable iff (!resetn) tx_go |=> ##1 rts;
  endproperty
  a_rts: assert property (p_rts) else $error("request not raised");
  property p_lost;
    @(posedge mclk) disable iff (!resetn)
      lost |-> idle_secs_reg >= idle_lim_reg ##1 (link_lost && !session_active);
  endproperty
  a_lost: assert property (p_lost) else $error("session not dropped");
  property p_idle_hold;
    @(posedge mclk) disable iff (!resetn)
      session_active && idle_secs_reg < idle_lim_reg |=> session_active || $past(rx_good);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("early drop");
  property p_id_first;
    @(posedge mclk) disable iff (!resetn) station_id[27:24] >= uspl_pkg::STATION_FIRST_MIN;
  endproperty
  a_id_first: assert property (p_id_first) else $error("bad first id char");
  property p_oe;
    @(posedge mclk) disable iff (!resetn) !cfg_reg.multidrop |=> txd_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("point link not driven");

  c_tx_done: cover property (@(posedge mclk) disable iff (!resetn) tx_last);
  c_rx_good: cover property (@(posedge mclk) disable iff (!resetn) rx_good);
  c_lost:    cover property (@(posedge mclk) disable iff (!resetn) lost);
  c_par_bad: cover property (@(posedge mclk) disable iff (!resetn) par_bad);
endmodule : uspl_top
`default_nettype wire

// >>> dv/uspl_host_model.sv
// behavioural upgrade program on the far end of the serial line
`timescale 1ns/100ps
`default_nettype none
module uspl_host_model (
  // clock
  input  wire logic        mclk,
  // line settings, equal to the port's
  input  wire logic [15:0] bit_cyc,
  input  wire logic [1:0]  par,
  input  wire logic        stop2,
  // serial line
  input  wire logic        txd,
  output logic             rxd
);
  logic [7:0]  rx_byte;
  logic        rx_ok;
  int unsigned rx_count;
  logic        good;
  wire logic   use_par = (par == uspl_pkg::PAR_ODD) || (par == uspl_pkg::PAR_EVEN);

  // line idles at mark between characters
  initial
  begin
    rxd      = 1'b1;
    rx_byte  = 8'h00;
    rx_ok    = 1'b0;
    rx_count = 0;
  end

  function automatic logic par_of(input logic [7:0] d);
    return (par == uspl_pkg::PAR_ODD) ? ~(^d) : ^d;
  endfunction : par_of

  task automatic bit_wait;
    repeat (bit_cyc) @(posedge mclk);
  endtask : bit_wait

  // frame sent with the port's settings
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [11:0] f;
    int          nb;
    nb = use_par ? 10 : 9;
    f  = use_par ? {2'b11, par_of(d) ^ bad_par, d, 1'b0} : {3'b111, d, 1'b0};
    f[nb] = ~bad_stop;
    for (int i = 0; i < nb + (stop2 ? 2 : 1); i++)
    begin
      rxd <= f[i];
      bit_wait();
    end
    rxd <= 1'b1;
  endtask : send

  // mid-bit decode, every stop bit checked
  always
  begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge mclk);
    good = ~txd;
    for (int i = 0; i < 8; i++)
    begin
      bit_wait();
      rx_byte[i] = txd;
    end
    if (use_par)
    begin
      bit_wait();
      good = good & (txd == par_of(rx_byte));
    end
    repeat (stop2 ? 2 : 1)
    begin
      bit_wait();
      good = good & txd;
    end
    rx_ok = good;
    rx_count++;
  end
endmodule : uspl_host_model
`default_nettype wire

// >>> dv/uspl_top_tb.sv
// self-checking bench of the upgrade serial port link
`timescale 1ns/100ps
`default_nettype none
module uspl_top_tb;
  // short counts keep bit times and seconds small
  localparam int unsigned CLK_HZ_TB = 768000;
  localparam uspl_pkg::uspl_parity_e PARS [4] = '{uspl_pkg::PAR_ODD, uspl_pkg::PAR_EVEN,
                                                  uspl_pkg::PAR_NONE,
                                                  uspl_pkg::uspl_parity_e'(2'h3)};
  logic        mclk, resetn, reg_wr, reg_rd, rxd, txd, txd_oe, rts;
  logic        session_active, link_lost, irq, m_stop2, irq_s, oe_s;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [27:0] station_id;
  logic [15:0] bit_cyc;
  uspl_pkg::uspl_parity_e m_par;
  int          errors, tests_run, lat;

  uspl_top #(.CLK_HZ(CLK_HZ_TB), .IDLE_UNIT_CYC(1000), .TURN_STEP_CYC(50)) u_dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .rts(rts), .session_active(session_active), .link_lost(link_lost),
    .station_id(station_id), .irq(irq));
  // released driver: line biased to mark
  uspl_host_model u_host (.mclk(mclk), .bit_cyc(bit_cyc), .par(m_par), .stop2(m_stop2),
    .txd(txd_oe ? txd : 1'b1), .rxd(rxd));

  always #12.5 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // strobe dropped one edge later so no two strobes meet in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    irq_s = irq;
    oe_s  = txd_oe;
    check(what, reg_rdata, exp);
    @(posedge mclk);
  endtask : rd

  task automatic set_cfg(input logic md, input uspl_pkg::uspl_parity_e p, input logic s2,
                         input logic [2:0] b);
    uspl_pkg::uspl_cfg_s c;
    c       = '{multidrop: md, parity: p, stop2: s2, baud: b};
    m_par   = p;
    m_stop2 = s2;
    bit_cyc = 16'(CLK_HZ_TB / uspl_pkg::BAUD_RATE[(b > 3'h6) ? 3'h6 : b]);
    wr(uspl_pkg::OFF_CTRL, {25'h0, c});
  endtask : set_cfg

  // lat counts cycles from the write edge to the start bit
  task automatic tx(input logic [7:0] d, input string what);
    int n;
    int base;
    base = u_host.rx_count;
    wr(uspl_pkg::OFF_TXDATA, {24'h0, d});
    #1;
    lat = 1;
    while (txd !== 1'b0 && lat < 20000)
    begin
      @(posedge mclk);
      #1;
      lat++;
    end
    check({what, " oe"}, 32'(txd_oe), 32'h1);
    n = 0;
    while (rts !== 1'b0 && n < 40000)
    begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    check({what, " count"}, 32'(u_host.rx_count - base), 32'h1);
    check({what, " byte"}, 32'(u_host.rx_byte), 32'(d));
    check({what, " frame"}, 32'(u_host.rx_ok), 32'h1);
  endtask : tx

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  initial
  begin
    // tests need about 66000 cycles, mostly the slow rates
    repeat (90000) @(posedge mclk);
    errors++;
    results();
  end

  initial
  begin
    mclk = 1'b0; resetn = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    reg_wr = 1'b0; reg_rd = 1'b0; errors = 0; tests_run = 0; lat = 0;
    m_par = uspl_pkg::PAR_ODD; m_stop2 = 1'b0; bit_cyc = 16'(CLK_HZ_TB / 19200);
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check("reset pins", 32'({txd, txd_oe, rts, irq, session_active}), 32'h18);
    check("station pin", 32'(station_id), 32'h0A000001);
    rd(uspl_pkg::OFF_CTRL, 32'h16, "ctrl reset");
    rd(uspl_pkg::OFF_IDLE, 32'h0A, "idle reset");
    rd(uspl_pkg::OFF_TURN, 32'h00, "turn reset");
    rd(uspl_pkg::OFF_STATION, 32'h0A000001, "station reset");
    rd(uspl_pkg::OFF_EV_EN, 32'h00, "enable reset");
    rd(8'h30, 32'h00, "unmapped");
    rd(uspl_pkg::OFF_EV_CLR, 32'h00, "clear reads zero");
    $display("test reset done");
    tx(8'hA5, "tx default");
    check("tx latency", 32'(lat), 32'h1);
    rd(uspl_pkg::OFF_EV_STAT, 32'h02, "ev tx");
    check("irq masked", 32'(irq_s), 32'h0);
    wr(uspl_pkg::OFF_EV_EN, 32'h02);
    wr(uspl_pkg::OFF_EV_STAT, 32'h00);
    rd(uspl_pkg::OFF_EV_STAT, 32'h02, "ev read only");
    check("irq enabled", 32'(irq_s), 32'h1);
    wr(uspl_pkg::OFF_EV_CLR, 32'h02);
    rd(uspl_pkg::OFF_EV_STAT, 32'h00, "ev cleared");
    check("irq cleared", 32'(irq_s), 32'h0);
    $display("test transmit and interrupt done");
    for (int k = 0; k < 4; k++)
    begin
      set_cfg(1'b0, PARS[k], k[0], 3'h6);
      wr(uspl_pkg::OFF_EV_CLR, 32'h3F);
      tx(8'(8'h5A + k), "tx mode");
      u_host.send(8'(8'hC3 ^ k), 1'b0, 1'b0);
      rd(uspl_pkg::OFF_EV_STAT, 32'h03, "ev mode");
      rd(uspl_pkg::OFF_RXDATA, 32'(8'(8'hC3 ^ k)), "rx mode");
    end
    set_cfg(1'b0, uspl_pkg::PAR_EVEN, 1'b0, 3'h6);
    wr(uspl_pkg::OFF_EV_CLR, 32'h3F);
    u_host.send(8'h96, 1'b1, 1'b0);
    rd(uspl_pkg::OFF_EV_STAT, 32'h04, "bad parity");
    wr(uspl_pkg::OFF_EV_CLR, 32'h3F);
    u_host.send(8'h69, 1'b0, 1'b1);
    rd(uspl_pkg::OFF_EV_STAT, 32'h08, "bad stop");
    $display("test parity and stop done");
    wr(uspl_pkg::OFF_IDLE, 32'h00);
    rd(uspl_pkg::OFF_IDLE, 32'h0A, "idle zero ignored");
    wr(uspl_pkg::OFF_IDLE, 32'h02);
    set_cfg(1'b0, uspl_pkg::PAR_ODD, 1'b0, 3'h6);
    wr(uspl_pkg::OFF_EV_CLR, 32'h3F);
    u_host.send(8'h11, 1'b0, 1'b0);
    rd(uspl_pkg::OFF_STATUS, 32'h06, "session open");
    repeat (1700) @(posedge mclk);
    check("session held", 32'(session_active), 32'h1);
    lat = 0;
    while (link_lost !== 1'b1 && lat < 600)
    begin
      @(posedge mclk);
      lat++;
    end
    check("loss in time", 32'(lat < 600), 32'h1);
    rd(uspl_pkg::OFF_STATUS, 32'h00, "after loss");
    rd(uspl_pkg::OFF_EV_STAT, 32'h11, "ev loss");
    wr(uspl_pkg::OFF_IDLE, 32'h0A);
    $display("test idle limit done");
    wr(uspl_pkg::OFF_EV_CLR, 32'h3F);
    wr(uspl_pkg::OFF_STATION, 32'h09123456);
    rd(uspl_pkg::OFF_STATION, 32'h0A000001, "station digit first");
    rd(uspl_pkg::OFF_EV_STAT, 32'h20, "ev id reject");
    wr(uspl_pkg::OFF_STATION, 32'h0BC0DE12);
    rd(uspl_pkg::OFF_STATION, 32'h0BC0DE12, "station new");
    check("station pin new", 32'(station_id), 32'h0BC0DE12);
    $display("test station done");
    // nonzero delay as with a modem in the path
    wr(uspl_pkg::OFF_TURN, 32'h03);
    tx(8'h0F, "tx turn");
    check("turn delay", 32'(lat >= 150 && lat <= 154), 32'h1);
    wr(uspl_pkg::OFF_TURN, 32'h00);
    set_cfg(1'b1, uspl_pkg::PAR_ODD, 1'b0, 3'h6);
    rd(uspl_pkg::OFF_CTRL, 32'h56, "ctrl multidrop");
    check("oe idle multidrop", 32'(oe_s), 32'h0);
    tx(8'h81, "tx multidrop");
    rd(uspl_pkg::OFF_STATUS, 32'h00, "multidrop idle");
    check("oe after frame", 32'(oe_s), 32'h0);
    $display("test turnaround and multidrop done");
    // code 7 runs at the fastest rate
    for (int b = 0; b < 8; b++)
    begin
      set_cfg(1'b0, uspl_pkg::PAR_ODD, 1'b0, b[2:0]);
      tx(8'(8'h30 + b), "tx baud");
    end
    $display("test baud rates done");
    results();
  end
endmodule : uspl_top_tb
`default_nettype wire
